// ==== dv/codac_prefetch_model.sv ====
/*
 * Prefetch queue model: hands the executed byte stream to the decoder.
 * Assumes the bench pushes bytes into stream in execution order.
 */
`timescale 1ns/10ps
module codac_prefetch_model (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// bench control
	input wire logic slow,
	// decoder side
	input wire logic byte_ready,
	input wire logic flush_req,
	input wire logic [15:0] flush_ip,
	output logic byte_valid,
	output logic [7:0] byte_data,
	output logic [15:0] fetch_ip
);
	logic [7:0] stream[$];
	logic gap;

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fetch_ip <= 16'h0000;
			byte_valid <= 1'b0;
			byte_data <= 8'h00;
			gap <= 1'b0;
		end else begin
			gap <= !gap;
			if (flush_req) begin
				fetch_ip <= flush_ip;
			end else if (byte_valid && byte_ready) begin
				fetch_ip <= fetch_ip + 16'h0001;
			end
			if (!byte_valid || byte_ready) begin
				if (stream.size() != 0 && (!slow || gap)) begin
					byte_valid <= 1'b1;
					byte_data <= stream.pop_front();
				end else begin
					// idle line moves every cycle so a stale byte never looks valid
					byte_valid <= 1'b0;
					byte_data <= ~byte_data;
				end
			end
		end
	end
endmodule : codac_prefetch_model

// ==== dv/codac_properties.sv ====
/*
 * Port checker for the opcode decoder.
 * Assumes it is bound into codac_decoder and sees a single clock domain.
 */
`timescale 1ns/10ps
module codac_properties (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// prefetch side
	input wire logic [7:0] byte_data,
	input wire logic [15:0] fetch_ip,
	input wire logic byte_ready,
	input wire logic flush_req,
	input wire logic [15:0] flush_ip,
	// decode results
	input wire logic op_valid,
	input wire codac_pkg::codac_op_e op_kind,
	input wire logic op_reg_mode,
	input wire logic [7:0] op_modrm
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////
	// single-byte ops: the byte taken just before the result is the opcode; for the adjust it is the second byte
	a_carry_clear: assert property (
		op_valid && op_kind == codac_pkg::OP_CARRY_CLEAR
		|-> $past(byte_data) == codac_pkg::OPC_CARRY_CLEAR)
		else $error("carry clear from another byte");
	a_dir_set: assert property (
		op_valid && op_kind == codac_pkg::OP_DIRECTION_SET
		|-> $past(byte_data) == codac_pkg::OPC_DIRECTION_SET)
		else $error("direction set from another byte");
	a_irq_clear: assert property (
		op_valid && op_kind == codac_pkg::OP_IRQ_ENABLE_CLEAR
		|-> $past(byte_data) == codac_pkg::OPC_IRQ_ENABLE_CLEAR)
		else $error("irq clear from another byte");
	a_widen_acc: assert property (
		op_valid && op_kind == codac_pkg::OP_WORD_SIGN_EXTEND
		|-> $past(byte_data) == codac_pkg::OPC_WORD_SIGN_EXTEND)
		else $error("sign extend from another byte");
	a_adjust_second: assert property (
		op_valid && op_kind == codac_pkg::OP_BCD_AFTER_MUL
		|-> $past(byte_data) == codac_pkg::BCD_SECOND_BYTE)
		else $error("adjust without its second byte");

	////////////////////////////////////////////////////////////////////////
	// taken branches and the register-mode flag
	a_flush_once: assert property (
		flush_req |-> !byte_ready ##1 !flush_req)
		else $error("flush not a single blocking pulse");
	a_branch_target: assert property (
		flush_req |-> op_valid && flush_ip == $past(fetch_ip) + 16'h0001
		+ 16'($signed($past(byte_data))))
		else $error("branch target wrong");
	a_mode_register: assert property (
		op_valid |-> op_reg_mode == (op_modrm[7:6] == codac_pkg::MOD_REGISTER))
		else $error("register mode flag wrong");
endmodule : codac_properties

bind codac_decoder codac_properties u_props (
	.clk(clk), .sys_rst(sys_rst), .byte_data(byte_data),
	.fetch_ip(fetch_ip), .byte_ready(byte_ready), .flush_req(flush_req),
	.flush_ip(flush_ip), .op_valid(op_valid), .op_kind(op_kind),
	.op_reg_mode(op_reg_mode), .op_modrm(op_modrm));

// ==== dv/tb_top.sv ====
/*
 * Self-checking bench for the opcode decoder: builds byte streams,
 * predicts every decode and compares; drives APB itself.
 * Assumes the prefetch model and the checker are compiled first.
 */
`timescale 1ns/10ps
module tb_top;
	localparam logic [47:0] MB = 48'hFB00_0000_0000;
	localparam logic [47:0] MW = 48'h0400_0000_0000;
	localparam logic [47:0] MM = 48'h00FF_0000_0000;
	localparam logic [47:0] MD = 48'h0000_FFFF_0000;
	localparam logic [47:0] MF = 48'h0000_0000_FFFF;
	logic clk, sys_rst, slow, byte_ready, flush_req, byte_valid;
	logic psel, penable, pwrite, pready, pslverr, op_valid, op_word;
	logic op_lock, lk, er;
	logic op_flags_only, count_dec, op_repeat, repeat_stop;
	logic [4:0] fl;
	logic [7:0] byte_data, paddr, op_modrm;
	logic [15:0] fetch_ip, flush_ip, cnt, op_disp, pc, op_imm;
	logic [31:0] pwdata, prdata, rd;
	codac_pkg::codac_op_e op_kind;
	logic [47:0] eq[$], mq[$];
	logic [19:0] xq[$];
	logic [7:0] f1[7] = '{8'hF8, 8'hF9, 8'hF5, 8'hFC, 8'hFD, 8'hFA, 8'hFB};
	logic [7:0] br[12] = '{8'h74, 8'h75, 8'h72, 8'h73, 8'h78, 8'h79,
		8'h7B, 8'h71, 8'h7D, 8'hE1, 8'hE0, 8'hE3};
	int fail_count, compares, taken_n;

	codac_decoder u_dut (
		.clk(clk), .sys_rst(sys_rst), .byte_valid(byte_valid),
		.byte_data(byte_data), .fetch_ip(fetch_ip), .byte_ready(byte_ready),
		.flush_req(flush_req), .flush_ip(flush_ip), .zero_flag(fl[0]),
		.carry_flag(fl[1]), .sign_flag(fl[2]), .overflow_flag(fl[3]),
		.parity_flag(fl[4]), .count_register(cnt), .op_valid(op_valid),
		.op_kind(op_kind), .op_word(op_word), .op_reg_mode(),
		.op_modrm(op_modrm), .op_disp(op_disp), .op_imm(op_imm),
		.op_flags_only(op_flags_only), .op_lock(op_lock),
		.op_repeat(op_repeat), .count_dec(count_dec),
		.repeat_stop(repeat_stop), .paddr(paddr), .psel(psel),
		.penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	codac_prefetch_model u_pq (
		.clk(clk), .sys_rst(sys_rst), .slow(slow), .byte_ready(byte_ready),
		.flush_req(flush_req), .flush_ip(flush_ip), .byte_valid(byte_valid),
		.byte_data(byte_data), .fetch_ip(fetch_ip));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [47:0] got, input logic [47:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	task automatic report_and_stop;
		$display("compares %0d errors %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic put(input logic [7:0] b);
		u_pq.stream.push_back(b);
		pc = pc + 16'h0001;
	endtask : put

	task automatic want(input logic [47:0] e, input logic [47:0] m,
		input logic [19:0] x = 20'h0_0000);
		eq.push_back(e & m);
		mq.push_back(m);
		xq.push_back(x);
		lk = 1'b0;
	endtask : want

	////////////////////////////////////////////////////////////////////////
	// one stream: flag ops, adjusts, escape, arithmetic group, branches
	task automatic stage(input int r);
		logic [7:0] b, d;
		logic [15:0] s;
		logic [11:0] tk;
		logic t;
		@(posedge clk);
		fl <= 5'($urandom);
		cnt <= (r % 3 == 0) ? 16'h0000 : (r % 3 == 1) ? 16'h0001 : 16'($urandom);
		slow <= 1'($urandom);
		@(posedge clk);
		put(8'hF0);
		lk = 1'b1;
		for (int i = 0; i < 7; i++) begin
			put(f1[i]);
			want({5'(i + 1), 1'b0, lk, 41'h0}, MB);
		end
		// repeat prefix in front: stop flag follows zero flag against z
		t = 1'($urandom);
		put(8'hF2 + 8'(t));
		put(8'h99);
		want({5'h1A, 43'h0}, MB,
			{2'h0, 1'b1, fl[0] != t, 16'h0});
		for (int i = 0; i < 2; i++) begin
			put(8'hD4 + 8'(i));
			put(8'h0A);
			want({5'h18 + 5'(i), 43'h0}, MB, 20'h0_000A);
		end
		b = {2'h3, 6'($urandom)};
		put(8'hD8 + 8'($urandom % 8));
		put(b);
		want({5'h08, 3'h0, b, 32'h0}, MB | MM);
		for (int i = 0; i < 3; i++) begin
			t = 1'($urandom);
			b = {($urandom % 2) ? 2'h1 : 2'h3, 3'(4 + i), 3'($urandom)};
			d = 8'($urandom);
			put(8'hF6 + 8'(t));
			put(b);
			if (b[7:6] == 2'h1) begin
				put(d);
			end
			want({5'h15 + 5'(i), t, 2'h0, b, {{8{d[7]}}, d}, 16'h0},
				MB | MW | MM | (b[7:6] == 2'h1 ? MD : 48'h0));
		end
		// bit test: accumulator immediate form, then group sub 000 form
		for (int i = 0; i < 2; i++) begin
			t = 1'($urandom);
			b = {2'h3, 3'h0, 3'($urandom)};
			s = {t ? 8'($urandom) : 8'h00, 8'($urandom)};
			put((i ? 8'hF6 : 8'hA8) + 8'(t));
			if (i)
				put(b);
			put(s[7:0]);
			if (t)
				put(s[15:8]);
			want({5'h1B, t, 2'h0, i ? b : 8'h00, 32'h0}, MB | MW | MM,
				{4'h8, s});
		end
		tk = {cnt == 16'h0000, cnt != 16'h0001 && !fl[0],
			cnt != 16'h0001 && fl[0], fl[2] == fl[3], !fl[3], !fl[4],
			!fl[2], fl[2], !fl[1], fl[1], !fl[0], fl[0]};
		for (int i = 0; i < 12; i++) begin
			d = 8'($urandom);
			put(br[i]);
			put(d);
			t = tk[i];
			s = pc + {{8{d[7]}}, d};
			if (t) begin
				pc = s;
				taken_n++;
			end
			want({5'h09 + 5'(i), 2'h0, t, 8'h00, {{8{d[7]}}, d}, t ? s : 16'h0},
				MB | MD | (t ? MF : 48'h0),
				{1'b0, i == 9 || i == 10, 18'h0});
		end
	endtask : stage

	task automatic drain;
		int n = 0;
		while (eq.size() != 0 && n < 600) begin
			@(posedge clk);
			n++;
		end
		check(48'(eq.size()), 48'h0);
	endtask : drain

	always @(posedge clk) begin
		if (op_valid === 1'b1) begin
			if (eq.size() == 0) begin
				check(48'h1, 48'h0);
			end else begin
				check({op_kind, op_word, op_lock, flush_req, op_modrm, op_disp,
					flush_ip} & mq[0], eq[0]);
				check(48'({op_flags_only, count_dec, op_repeat, repeat_stop,
					op_imm}), 48'(xq[0]));
				void'(eq.pop_front());
				void'(mq.pop_front());
				void'(xq.pop_front());
			end
		end
	end

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		report_and_stop;
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(38));
		fail_count = 0;
		compares = 0;
		taken_n = 0;
		pc = 16'h0000;
		lk = 1'b0;
		{sys_rst, slow, fl, cnt} = {1'b1, 22'h0};
		{psel, penable, pwrite, paddr, pwdata} = 43'h0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		apb(1'b0, 8'h00, 32'h0);
		check(48'(rd), 48'h1);
		apb(1'b0, 8'h08, 32'h0);
		check(48'(rd), 48'h0);
		apb(1'b0, 8'h0C, 32'h0);
		check(48'({er, rd}), 48'h1_0000_0000);
		// decode held off: the first stream must wait for the enable
		apb(1'b1, 8'h00, 32'h0);
		for (int r = 0; r < 12; r++) begin
			stage(r);
			if (r == 0) begin
				repeat (10) @(posedge clk);
				check(48'({byte_ready, op_valid}), 48'h0);
				apb(1'b1, 8'h00, 32'h1);
			end
			drain;
		end
		// idle decoder: last kind is the count-empty branch, no prefixes
		apb(1'b0, 8'h04, 32'h0);
		check(48'(rd[17:0]), 48'h0114);
		apb(1'b0, 8'h08, 32'h0);
		check(48'(rd[15:0]), 48'(taken_n));
		apb(1'b1, 8'h08, 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		check(48'(rd), 48'h0);
		report_and_stop;
	end
endmodule : tb_top

// ==== rtl/codac_decoder.sv ====
/*
 * Opcode decoder for multiply/divide, decimal adjust, convert, bit test,
 * conditional branch, count loop and processor-control instructions.
 * Assumes the prefetch queue, flag inputs and APB master share clk;
 * the queue drops its content on flush_req and refetches at flush_ip.
 */
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps

module codac_decoder (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// prefetch queue side
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	input wire logic [15:0] fetch_ip,
	output logic byte_ready,
	output logic flush_req,
	output logic [15:0] flush_ip,
	// execution unit state
	input wire logic zero_flag,
	input wire logic carry_flag,
	input wire logic sign_flag,
	input wire logic overflow_flag,
	input wire logic parity_flag,
	input wire logic [15:0] count_register,
	// decoded instruction
	output logic op_valid,
	output codac_pkg::codac_op_e op_kind,
	output logic op_word,
	output logic op_reg_mode,
	output logic [7:0] op_modrm,
	output logic [15:0] op_disp,
	output logic [15:0] op_imm,
	output logic op_flags_only,
	output logic op_lock,
	output logic op_repeat,
	output logic count_dec,
	output logic repeat_stop,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		codac_pkg::codac_state_e state;
		codac_pkg::codac_op_e op;
		logic [7:0] opc;
		logic [7:0] modrm;
		logic word;
		logic reg_mode;
		logic flags_only;
		logic group_op;
		logic lock_pend;
		logic rep_pend;
		logic rep_z;
		logic [1:0] disp_cnt;
		logic disp_two;
		logic [1:0] imm_cnt;
		logic imm_two;
		logic [15:0] disp;
		logic [15:0] imm;
		logic op_valid;
		logic out_lock;
		logic out_rep;
		logic count_dec;
		logic rep_stop;
		logic flush;
		logic [15:0] flush_ip;
		logic [15:0] taken_cnt;
		logic ctrl_en;
		logic [31:0] prdata;
		logic pslverr;
	} codac_regs_s;

	codac_regs_s r;
	codac_regs_s n;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic take;
		logic issue;
		logic taken;
		logic [7:0] b;
		logic [15:0] sdisp;
		logic [15:0] cnt_m1;
		take = byte_valid & byte_ready;
		issue = 1'b0;
		taken = 1'b0;
		b = byte_data;
		sdisp = {{8{byte_data[7]}}, byte_data};
		cnt_m1 = count_register - 16'h0001;
		n = r;
		n.op_valid = 1'b0;
		n.count_dec = 1'b0;
		n.flush = 1'b0;
		// sampled against the live zero flag every cycle
		n.rep_stop = r.rep_pend & (zero_flag != r.rep_z);

		// register bus: read data is latched in setup, zero wait states
		if (psel & ~penable) begin
			n.pslverr = 1'b0;
			case (paddr)
			codac_pkg::ADDR_CTRL: begin
				n.prdata = 32'h0000_0000;
				n.prdata[codac_pkg::CTRL_ENABLE_BIT] = r.ctrl_en;
			end
			codac_pkg::ADDR_STATUS: begin
				n.prdata = 32'h0000_0000;
				n.prdata[codac_pkg::STAT_OP_LSB +: 5] = r.op;
				n.prdata[codac_pkg::STAT_STATE_LSB +: 6] = r.state;
				n.prdata[codac_pkg::STAT_LOCK_BIT] = r.lock_pend;
				n.prdata[codac_pkg::STAT_REPEAT_BIT] = r.rep_pend;
				n.prdata[codac_pkg::STAT_REPEAT_Z_BIT] = r.rep_z;
			end
			codac_pkg::ADDR_TAKEN: begin
				n.prdata = {16'h0000, r.taken_cnt};
			end
			default: begin
				n.prdata = 32'h0000_0000;
				n.pslverr = 1'b1;
			end
			endcase
		end
		if (psel & penable & pwrite) begin
			case (paddr)
			codac_pkg::ADDR_CTRL: begin
				if (pstrb[0])
					n.ctrl_en = pwdata[codac_pkg::CTRL_ENABLE_BIT];
			end
			// cleared here; a branch in the same cycle still counts below
			codac_pkg::ADDR_TAKEN: n.taken_cnt = codac_pkg::TAKEN_RESET;
			default: ;
			endcase
		end

		if (take) begin
			case (r.state)
			codac_pkg::ST_OPCODE: begin
				n.opc = b;
				n.modrm = 8'h00;
				n.word = 1'b0;
				n.reg_mode = 1'b0;
				n.flags_only = 1'b0;
				n.group_op = 1'b0;
				n.disp = 16'h0000;
				n.imm = 16'h0000;
				n.disp_cnt = 2'd0;
				n.imm_cnt = 2'd0;
				n.disp_two = 1'b0;
				n.imm_two = 1'b0;
				case (b)
				// prefix only arms the next instruction
				codac_pkg::OPC_BUS_LOCK: n.lock_pend = 1'b1;
				codac_pkg::OPC_CARRY_CLEAR: begin
					n.op = codac_pkg::OP_CARRY_CLEAR;
					issue = 1'b1;
				end
				codac_pkg::OPC_CARRY_SET: begin
					n.op = codac_pkg::OP_CARRY_SET;
					issue = 1'b1;
				end
				codac_pkg::OPC_CARRY_INVERT: begin
					n.op = codac_pkg::OP_CARRY_INVERT;
					issue = 1'b1;
				end
				codac_pkg::OPC_DIRECTION_CLEAR: begin
					n.op = codac_pkg::OP_DIRECTION_CLEAR;
					issue = 1'b1;
				end
				codac_pkg::OPC_DIRECTION_SET: begin
					n.op = codac_pkg::OP_DIRECTION_SET;
					issue = 1'b1;
				end
				codac_pkg::OPC_IRQ_ENABLE_CLEAR: begin
					n.op = codac_pkg::OP_IRQ_ENABLE_CLEAR;
					issue = 1'b1;
				end
				codac_pkg::OPC_IRQ_ENABLE_SET: begin
					n.op = codac_pkg::OP_IRQ_ENABLE_SET;
					issue = 1'b1;
				end
				codac_pkg::OPC_WORD_SIGN_EXTEND: begin
					n.op = codac_pkg::OP_WORD_SIGN_EXTEND;
					n.word = 1'b1;
					issue = 1'b1;
				end
				codac_pkg::OPC_BCD_AFTER_MUL: begin
					n.op = codac_pkg::OP_BCD_AFTER_MUL;
					n.state = codac_pkg::ST_SECOND;
				end
				codac_pkg::OPC_BCD_BEFORE_DIV: begin
					n.op = codac_pkg::OP_BCD_BEFORE_DIV;
					n.state = codac_pkg::ST_SECOND;
				end
				codac_pkg::OPC_BR_ZERO: begin
					n.op = codac_pkg::OP_BR_ZERO;
					n.state = codac_pkg::ST_BRDISP;
				end
				codac_pkg::OPC_BR_NONZERO: begin
					n.op = codac_pkg::OP_BR_NONZERO;
					n.state = codac_pkg::ST_BRDISP;
				end
				codac_pkg::OPC_BR_BELOW: begin
					n.op = codac_pkg::OP_BR_BELOW;
					n.state = codac_pkg::ST_BRDISP;
				end
				codac_pkg::OPC_BR_NOT_BELOW: begin
					n.op = codac_pkg::OP_BR_NOT_BELOW;
					n.state = codac_pkg::ST_BRDISP;
				end
				codac_pkg::OPC_BR_NEGATIVE: begin
					n.op = codac_pkg::OP_BR_NEGATIVE;
					n.state = codac_pkg::ST_BRDISP;
				end
				codac_pkg::OPC_BR_POSITIVE: begin
					n.op = codac_pkg::OP_BR_POSITIVE;
					n.state = codac_pkg::ST_BRDISP;
				end
				codac_pkg::OPC_BR_PARITY_ODD: begin
					n.op = codac_pkg::OP_BR_PARITY_ODD;
					n.state = codac_pkg::ST_BRDISP;
				end
				codac_pkg::OPC_BR_NO_OVERFLOW: begin
					n.op = codac_pkg::OP_BR_NO_OVERFLOW;
					n.state = codac_pkg::ST_BRDISP;
				end
				codac_pkg::OPC_BR_SIGNED_GE: begin
					n.op = codac_pkg::OP_BR_SIGNED_GE;
					n.state = codac_pkg::ST_BRDISP;
				end
				codac_pkg::OPC_LOOP_WHILE_ZERO: begin
					n.op = codac_pkg::OP_LOOP_WHILE_ZERO;
					n.state = codac_pkg::ST_BRDISP;
				end
				codac_pkg::OPC_LOOP_WHILE_NONZERO: begin
					n.op = codac_pkg::OP_LOOP_WHILE_NONZERO;
					n.state = codac_pkg::ST_BRDISP;
				end
				codac_pkg::OPC_BR_COUNT_EMPTY: begin
					n.op = codac_pkg::OP_BR_COUNT_EMPTY;
					n.state = codac_pkg::ST_BRDISP;
				end
				default: begin
					if (b[7:1] == codac_pkg::PFX_STRING_REPEAT) begin
						n.rep_pend = 1'b1;
						n.rep_z = b[0];
					end else if (b[7:3] == codac_pkg::PFX_EXTERNAL_ESCAPE) begin
						n.op = codac_pkg::OP_EXTERNAL_ESCAPE;
						n.state = codac_pkg::ST_MODRM;
					end else if (b[7:1] == codac_pkg::PFX_ARITH_GROUP) begin
						// kind is settled by the sub-operation field
						n.op = codac_pkg::OP_UNKNOWN;
						n.group_op = 1'b1;
						n.word = b[0];
						n.state = codac_pkg::ST_MODRM;
					end else if (b[7:1] == codac_pkg::PFX_TEST_REG_MEM) begin
						n.op = codac_pkg::OP_BIT_TEST;
						n.flags_only = 1'b1;
						n.word = b[0];
						n.state = codac_pkg::ST_MODRM;
					end else if (b[7:1] == codac_pkg::PFX_TEST_ACC_IMM) begin
						n.op = codac_pkg::OP_BIT_TEST;
						n.flags_only = 1'b1;
						n.word = b[0];
						n.imm_two = b[0];
						n.imm_cnt = b[0] ? 2'd2 : 2'd1;
						n.state = codac_pkg::ST_IMM;
					end else begin
						// not handled here: reported so the core can trap
						n.op = codac_pkg::OP_UNKNOWN;
						issue = 1'b1;
					end
				end
				endcase
			end
			codac_pkg::ST_MODRM: begin
				n.modrm = b;
				n.reg_mode = (b[7:6] == codac_pkg::MOD_REGISTER);
				if (r.group_op) begin
					case (b[5:3])
					codac_pkg::SUB_SIGNED_MULTIPLY:
						n.op = codac_pkg::OP_SIGNED_MULTIPLY;
					codac_pkg::SUB_UNSIGNED_MULTIPLY:
						n.op = codac_pkg::OP_UNSIGNED_MULTIPLY;
					codac_pkg::SUB_UNSIGNED_DIVIDE:
						n.op = codac_pkg::OP_UNSIGNED_DIVIDE;
					codac_pkg::SUB_TEST: begin
						n.op = codac_pkg::OP_BIT_TEST;
						n.flags_only = 1'b1;
						n.imm_two = r.word;
						n.imm_cnt = r.word ? 2'd2 : 2'd1;
					end
					default: n.op = codac_pkg::OP_UNKNOWN;
					endcase
				end
				case (b[7:6])
				codac_pkg::MOD_DISP8: begin
					n.disp_cnt = 2'd1;
					n.disp_two = 1'b0;
				end
				codac_pkg::MOD_DISP16: begin
					n.disp_cnt = 2'd2;
					n.disp_two = 1'b1;
				end
				codac_pkg::MOD_NO_DISP: begin
					n.disp_cnt = (b[2:0] == codac_pkg::RM_DIRECT) ? 2'd2 : 2'd0;
					n.disp_two = (b[2:0] == codac_pkg::RM_DIRECT);
				end
				default: begin
					n.disp_cnt = 2'd0;
					n.disp_two = 1'b0;
				end
				endcase
				if (n.disp_cnt != 2'd0)
					n.state = codac_pkg::ST_DISP;
				else if (n.imm_cnt != 2'd0)
					n.state = codac_pkg::ST_IMM;
				else
					issue = 1'b1;
			end
			codac_pkg::ST_DISP: begin
				// low byte first; a lone byte is sign-extended
				if (!r.disp_two || r.disp_cnt == 2'd2)
					n.disp = sdisp;
				else
					n.disp[15:8] = b;
				n.disp_cnt = r.disp_cnt - 2'd1;
				if (r.disp_cnt == 2'd1) begin
					if (r.imm_cnt != 2'd0)
						n.state = codac_pkg::ST_IMM;
					else
						issue = 1'b1;
				end
			end
			codac_pkg::ST_IMM: begin
				if (!r.imm_two || r.imm_cnt == 2'd2)
					n.imm = {8'h00, b};
				else
					n.imm[15:8] = b;
				n.imm_cnt = r.imm_cnt - 2'd1;
				if (r.imm_cnt == 2'd1)
					issue = 1'b1;
			end
			codac_pkg::ST_SECOND: begin
				n.imm = {8'h00, b};
				if (b != codac_pkg::BCD_SECOND_BYTE)
					n.op = codac_pkg::OP_UNKNOWN;
				issue = 1'b1;
			end
			codac_pkg::ST_BRDISP: begin
				n.disp = sdisp;
				case (r.op)
				codac_pkg::OP_BR_ZERO: taken = zero_flag;
				codac_pkg::OP_BR_NONZERO: taken = ~zero_flag;
				codac_pkg::OP_BR_BELOW: taken = carry_flag;
				codac_pkg::OP_BR_NOT_BELOW: taken = ~carry_flag;
				codac_pkg::OP_BR_NEGATIVE: taken = sign_flag;
				codac_pkg::OP_BR_POSITIVE: taken = ~sign_flag;
				// parity flag is high for even parity
				codac_pkg::OP_BR_PARITY_ODD: taken = ~parity_flag;
				codac_pkg::OP_BR_NO_OVERFLOW:
					taken = ~overflow_flag;
				codac_pkg::OP_BR_SIGNED_GE:
					taken = (sign_flag == overflow_flag);
				codac_pkg::OP_LOOP_WHILE_ZERO: begin
					n.count_dec = 1'b1;
					taken = (cnt_m1 != 16'h0000) & zero_flag;
				end
				codac_pkg::OP_LOOP_WHILE_NONZERO: begin
					n.count_dec = 1'b1;
					taken = (cnt_m1 != 16'h0000) & ~zero_flag;
				end
				codac_pkg::OP_BR_COUNT_EMPTY:
					taken = (count_register == 16'h0000);
				default: taken = 1'b0;
				endcase
				if (taken) begin
					// target counts from the byte right after the disp byte
					n.flush_ip = fetch_ip + 16'h0001 + sdisp;
					n.flush = 1'b1;
				end
				issue = 1'b1;
			end
			default: n.state = codac_pkg::ST_OPCODE;
			endcase
		end

		if (n.flush)
			n.taken_cnt = n.taken_cnt + 16'h0001;
		if (issue) begin
			n.op_valid = 1'b1;
			n.out_lock = r.lock_pend;
			n.out_rep = r.rep_pend;
			n.lock_pend = 1'b0;
			n.rep_pend = 1'b0;
			n.state = codac_pkg::ST_OPCODE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '0;
			r.state <= codac_pkg::ST_OPCODE;
			r.op <= codac_pkg::OP_NONE;
			r.ctrl_en <= codac_pkg::CTRL_ENABLE_RESET;
			r.taken_cnt <= codac_pkg::TAKEN_RESET;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	// no new byte is taken while the queue is being flushed
	assign byte_ready = r.ctrl_en & ~r.flush;
	assign flush_req = r.flush;
	assign flush_ip = r.flush_ip;
	assign op_valid = r.op_valid;
	assign op_kind = r.op;
	assign op_word = r.word;
	assign op_reg_mode = r.reg_mode;
	assign op_modrm = r.modrm;
	assign op_disp = r.disp;
	assign op_imm = r.imm;
	assign op_flags_only = r.flags_only;
	assign op_lock = r.out_lock;
	assign op_repeat = r.out_rep;
	assign count_dec = r.count_dec;
	assign repeat_stop = r.rep_stop;
	assign prdata = r.prdata;
	assign pready = 1'b1;
	assign pslverr = r.pslverr;

endmodule : codac_decoder

// ==== rtl/codac_pkg.sv ====
/*
 * Shared constants for the opcode decoder: first and second byte
 * encodings, decoded operation kinds, decode states and the register map.
 * Assumes a byte-wide prefetch path and a 32-bit APB register bus.
 */
package codac_pkg;

	////////////////////////////////////////////////////////////////////////
	// single-byte and prefix encodings
	localparam logic [7:0] OPC_CARRY_CLEAR = 8'hF8;
	localparam logic [7:0] OPC_CARRY_SET = 8'hF9;
	localparam logic [7:0] OPC_CARRY_INVERT = 8'hF5;
	localparam logic [7:0] OPC_DIRECTION_CLEAR = 8'hFC;
	localparam logic [7:0] OPC_DIRECTION_SET = 8'hFD;
	localparam logic [7:0] OPC_IRQ_ENABLE_CLEAR = 8'hFA;
	localparam logic [7:0] OPC_IRQ_ENABLE_SET = 8'hFB;
	localparam logic [7:0] OPC_BUS_LOCK = 8'hF0;
	localparam logic [7:0] OPC_WORD_SIGN_EXTEND = 8'h99;
	localparam logic [7:0] OPC_BCD_AFTER_MUL = 8'hD4;
	localparam logic [7:0] OPC_BCD_BEFORE_DIV = 8'hD5;
	localparam logic [7:0] BCD_SECOND_BYTE = 8'h0A;

	// pattern prefixes, upper bits of the first byte
	localparam logic [4:0] PFX_EXTERNAL_ESCAPE = 5'h1B;
	localparam logic [6:0] PFX_STRING_REPEAT = 7'h79;
	localparam logic [6:0] PFX_ARITH_GROUP = 7'h7B;
	localparam logic [6:0] PFX_TEST_REG_MEM = 7'h42;
	localparam logic [6:0] PFX_TEST_ACC_IMM = 7'h54;

	////////////////////////////////////////////////////////////////////////
	// conditional branch and loop encodings
	localparam logic [7:0] OPC_BR_ZERO = 8'h74;
	localparam logic [7:0] OPC_BR_NONZERO = 8'h75;
	localparam logic [7:0] OPC_BR_BELOW = 8'h72;
	localparam logic [7:0] OPC_BR_NOT_BELOW = 8'h73;
	localparam logic [7:0] OPC_BR_NEGATIVE = 8'h78;
	localparam logic [7:0] OPC_BR_POSITIVE = 8'h79;
	localparam logic [7:0] OPC_BR_PARITY_ODD = 8'h7B;
	localparam logic [7:0] OPC_BR_NO_OVERFLOW = 8'h71;
	localparam logic [7:0] OPC_BR_SIGNED_GE = 8'h7D;
	localparam logic [7:0] OPC_LOOP_WHILE_ZERO = 8'hE1;
	localparam logic [7:0] OPC_LOOP_WHILE_NONZERO = 8'hE0;
	localparam logic [7:0] OPC_BR_COUNT_EMPTY = 8'hE3;

	////////////////////////////////////////////////////////////////////////
	// mode/register-memory byte fields
	localparam logic [2:0] SUB_TEST = 3'h0;
	localparam logic [2:0] SUB_UNSIGNED_MULTIPLY = 3'h4;
	localparam logic [2:0] SUB_SIGNED_MULTIPLY = 3'h5;
	localparam logic [2:0] SUB_UNSIGNED_DIVIDE = 3'h6;
	localparam logic [1:0] MOD_NO_DISP = 2'h0;
	localparam logic [1:0] MOD_DISP8 = 2'h1;
	localparam logic [1:0] MOD_DISP16 = 2'h2;
	localparam logic [1:0] MOD_REGISTER = 2'h3;
	localparam logic [2:0] RM_DIRECT = 3'h6;

	////////////////////////////////////////////////////////////////////////
	// decoded operation kinds
	typedef enum logic [4:0] {
		OP_NONE = 5'h00,
		OP_CARRY_CLEAR = 5'h01,
		OP_CARRY_SET = 5'h02,
		OP_CARRY_INVERT = 5'h03,
		OP_DIRECTION_CLEAR = 5'h04,
		OP_DIRECTION_SET = 5'h05,
		OP_IRQ_ENABLE_CLEAR = 5'h06,
		OP_IRQ_ENABLE_SET = 5'h07,
		OP_EXTERNAL_ESCAPE = 5'h08,
		OP_BR_ZERO = 5'h09,
		OP_BR_NONZERO = 5'h0A,
		OP_BR_BELOW = 5'h0B,
		OP_BR_NOT_BELOW = 5'h0C,
		OP_BR_NEGATIVE = 5'h0D,
		OP_BR_POSITIVE = 5'h0E,
		OP_BR_PARITY_ODD = 5'h0F,
		OP_BR_NO_OVERFLOW = 5'h10,
		OP_BR_SIGNED_GE = 5'h11,
		OP_LOOP_WHILE_ZERO = 5'h12,
		OP_LOOP_WHILE_NONZERO = 5'h13,
		OP_BR_COUNT_EMPTY = 5'h14,
		OP_UNSIGNED_MULTIPLY = 5'h15,
		OP_SIGNED_MULTIPLY = 5'h16,
		OP_UNSIGNED_DIVIDE = 5'h17,
		OP_BCD_AFTER_MUL = 5'h18,
		OP_BCD_BEFORE_DIV = 5'h19,
		OP_WORD_SIGN_EXTEND = 5'h1A,
		OP_BIT_TEST = 5'h1B,
		OP_UNKNOWN = 5'h1F
	} codac_op_e;

	// decode states, one-hot
	typedef enum logic [5:0] {
		ST_OPCODE = 6'h01,
		ST_MODRM = 6'h02,
		ST_DISP = 6'h04,
		ST_IMM = 6'h08,
		ST_SECOND = 6'h10,
		ST_BRDISP = 6'h20
	} codac_state_e;

	////////////////////////////////////////////////////////////////////////
	// register map, byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TAKEN = 8'h08;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam logic CTRL_ENABLE_RESET = 1'b1;
	localparam int STAT_OP_LSB = 0;
	localparam int STAT_STATE_LSB = 8;
	localparam int STAT_LOCK_BIT = 16;
	localparam int STAT_REPEAT_BIT = 17;
	localparam int STAT_REPEAT_Z_BIT = 18;
	localparam logic [15:0] TAKEN_RESET = 16'h0000;

endpackage : codac_pkg
